/* rtl/msp_host_port.sv */
// SPI slave port giving an external host word access to the metering RAM
// Functional notes
// R01: A framed transaction holds exactly 64 serial clocks, every field present.
// R02: Transactions of any other length are rejected and perform no access; the code still reads the RAM for a read frame of 32 or more clocks.
// R03: An address or direction error means no read or write happens.
// R04: Surplus clocks after a read shift out zeros and flag an error.
// R05: Surplus clocks after a write abort the write and flag an error.
// R06: Status byte reports the previous transaction; its parity covers the byte sent.
// R07: Restricted-window mode allows only addresses 0x00 to 0xFF.
// R08: Native and redundant-command modes, chosen by firmware through a control bit.
// R09: Redundant mode checks the address copy against the address before access.
// R10: Byte sequence A2 01 07 F9 E6 resets the device, last bit ignored.
// R11: Read frame: address, trailing 1, inverted address, trailing 0, four don't-care bytes.
// R12: Write frame: address, trailing 0, reversed copy, trailing 1, pad byte, data.
// R13: Even parity is computed for the data word and the status byte.
// R14: Status bit 7 parity, bit 6 overrun, bit 5 underrun.
// R15: Status bit 4 data parity, bit 3 mismatch, bit 2 reserved.
// R16: Status bit 1 bad clock count, bit 0 out-of-window address.
// R17: Input sampled on rising serial clock, output changes after falling edge.
// R18: Reads send status then 24-bit data, MSB first, in the last four bytes.
// R19: Transaction runs from chip select falling to rising; counting restarts each time.
`timescale 1ns/100ps

module msp_host_port (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        ce,
    input  wire logic        spi_sck,
    input  wire logic        chip_select_n,
    input  wire logic        spi_mosi,
    output logic             spi_miso,
    output logic             spi_miso_oe,
    output logic             dev_reset_req,
    output logic             irq,
    output logic             mem_req,
    output logic             mem_we,
    output logic [14:0]      mem_addr,
    output logic [23:0]      mem_wdata,
    input  wire logic        mem_ack,
    input  wire logic [23:0] mem_rdata,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata
);

    typedef struct packed {
        logic [63:0] sr;
        logic [6:0]  cnt;
        logic        miso;
        logic        oe;
        logic [14:0] addr;
        logic        is_read;
        logic        mism;
        logic        bad_addr;
        logic        rd_want;
        logic        rd_ok;
        logic [23:0] rdata;
        logic        und;
        logic [6:0]  status;
        logic        rst_seen;
        logic        rst_pulse;
        logic        req;
        logic        we;
        logic [14:0] maddr;
        logic [23:0] wdata;
        logic [1:0]  ctrl;
        logic [2:0]  istat;
        logic [2:0]  imask;
        logic        wr_pend;
        logic [7:0]  woff;
        logic [31:0] hrdata;
    } msp_state_t;

    msp_state_t s_q;
    msp_state_t s_d;

    logic cs_n;
    logic cs_rise;
    logic cs_fall;
    logic sck_rise;
    logic sck_fall;
    logic mosi;
    logic sck_unused_lvl;
    logic mosi_unused_rise;
    logic mosi_unused_fall;

    // ==========================================================
    // Pin synchronisers
    msp_pin_sync #(
        .W       (3),
        .RST_VAL (3'h4)
    ) u_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .ce      (ce),
        .din     ({chip_select_n, spi_sck, spi_mosi}),
        .lvl     ({cs_n, sck_unused_lvl, mosi}),
        .rise    ({cs_rise, sck_rise, mosi_unused_rise}),
        .fall    ({cs_fall, sck_fall, mosi_unused_fall})
    );

    // ==========================================================
    // Helpers
    function automatic logic [14:0] rev15(input logic [14:0] a);
        logic [14:0] r;
        r = '0;
        for (int i = 0; i < 15; i++)
            r[i] = a[14 - i];
        return r;
    endfunction : rev15

    function automatic logic out_bit(input logic [6:0] cnt, input logic [6:0] st,
                                     input logic [23:0] rd, input logic rd_valid);
        logic [7:0] sb;
        sb = {^st, st};
        if (cnt >= msp_pkg::STATUS_START && cnt < msp_pkg::DATA_START)
            return sb[3'(7'h27 - cnt)];
        else if (cnt >= msp_pkg::DATA_START && cnt < msp_pkg::TXN_BITS && rd_valid)
            return rd[5'(7'h3F - cnt)];
        return 1'h0;
    endfunction : out_bit

    // ==========================================================
    // Next state
    always_comb
    begin
        logic [31:0] fr;
        logic [14:0] a;
        logic        rd_dir;
        logic        dir_bad;
        logic        copy_bad;
        logic        ovr;
        logic        wr_ok;
        logic [2:0]  ev;
        logic [2:0]  clr;
        logic [6:0]  st;
        fr       = {s_q.sr[30:0], mosi};
        a        = fr[31:17];
        rd_dir   = fr[16];
        dir_bad  = (fr[16] == fr[0]);
        copy_bad = rd_dir ? (fr[15:1] != ~a) : (fr[15:1] != rev15(a));
        ovr      = 1'h0;
        wr_ok    = 1'h0;
        ev       = 3'h0;
        clr      = 3'h0;
        st       = 7'h00;
        s_d      = s_q;
        s_d.rst_pulse = 1'h0;
        s_d.wr_pend   = 1'h0;

        // Register write data phase
        if (s_q.wr_pend)
        begin
            unique case (s_q.woff)
                msp_pkg::OFS_CTRL:     s_d.ctrl  = hwdata[1:0];  // [R08] [R07]
                msp_pkg::OFS_IRQ_STAT: clr       = hwdata[2:0];
                msp_pkg::OFS_IRQ_MASK: s_d.imask = hwdata[2:0];
                default:               clr       = 3'h0;
            endcase
        end
        // Register address phase
        if (hsel && htrans[1] && hready)
        begin
            s_d.wr_pend = hwrite;
            s_d.woff    = haddr[7:0];
            if (!hwrite)
            begin
                unique case (haddr[7:0])
                    msp_pkg::OFS_CTRL:       s_d.hrdata = {30'h0000_0000, s_q.ctrl};
                    msp_pkg::OFS_IRQ_STAT:   s_d.hrdata = {29'h0000_0000, s_q.istat};
                    msp_pkg::OFS_IRQ_MASK:   s_d.hrdata = {29'h0000_0000, s_q.imask};
                    msp_pkg::OFS_SPI_STATUS: s_d.hrdata = {24'h00_0000, ^s_q.status, s_q.status};
                    default:                 s_d.hrdata = 32'h0000_0000;
                endcase
            end
        end

        // RAM port
        if (s_q.req && mem_ack)
        begin
            s_d.req = 1'h0;
            if (!s_q.we)
            begin
                s_d.rdata = mem_rdata;
                s_d.rd_ok = 1'h1;
            end
        end
        if (s_q.rd_want && !s_q.req)
        begin
            s_d.rd_want = 1'h0;
            s_d.req     = 1'h1;
            s_d.we      = 1'h0;
            s_d.maddr   = s_q.addr;
        end

        // Serial frame
        if (cs_fall)
        begin
            s_d.cnt      = 7'h00;                    // [R19]
            s_d.miso     = 1'h0;
            s_d.oe       = 1'h1;
            s_d.is_read  = 1'h0;
            s_d.mism     = 1'h0;
            s_d.bad_addr = 1'h0;
            s_d.rd_ok    = 1'h0;
            s_d.rd_want  = 1'h0;
            s_d.und      = 1'h0;
            s_d.rst_seen = 1'h0;
        end
        else if (!cs_n && sck_rise)
        begin
            s_d.sr = {s_q.sr[62:0], mosi};           // [R17]
            if (s_q.cnt != msp_pkg::CNT_MAX)
                s_d.cnt = 7'(s_q.cnt + 7'h01);
            if (s_q.cnt == msp_pkg::RST_LAST_CNT && s_q.sr[38:0] == msp_pkg::RESET_SEQ[39:1])
            begin
                s_d.rst_seen  = 1'h1;                // [R10]
                s_d.rst_pulse = 1'h1;
                ev[msp_pkg::EV_RESET_CMD] = 1'h1;
            end
            if (s_q.cnt == msp_pkg::ADDR_DONE_CNT)
            begin
                s_d.addr     = a;                    // [R11] [R12]
                s_d.is_read  = rd_dir;
                s_d.mism     = dir_bad || (s_q.ctrl[msp_pkg::CTRL_REDUNDANT] && copy_bad);  // [R09]
                s_d.bad_addr = s_q.ctrl[msp_pkg::CTRL_SAFE] && (a > msp_pkg::SAFE_LIMIT);   // [R07]
                s_d.rd_want  = rd_dir && !s_d.mism && !s_d.bad_addr;                        // [R03]
            end
        end
        else if (!cs_n && sck_fall)
        begin
            if (s_q.cnt == msp_pkg::DATA_START && s_q.is_read && !s_q.mism && !s_q.bad_addr && !s_q.rd_ok)
                s_d.und = 1'h1;
            s_d.miso = out_bit(s_q.cnt, s_q.status, s_q.rdata,
                               s_q.is_read && s_q.rd_ok && !s_q.und);  // [R18] [R04] [R06]
        end
        else if (cs_rise)
        begin
            s_d.oe      = 1'h0;
            s_d.miso    = 1'h0;
            s_d.rd_want = 1'h0;
            wr_ok = (s_q.cnt == msp_pkg::TXN_BITS) && !s_q.is_read && !s_q.mism
                    && !s_q.bad_addr && !s_q.rst_seen;    // [R01] [R02] [R05]
            ovr   = wr_ok && s_q.req;
            st[msp_pkg::ST_OVERRUN]   = ovr;                                        // [R14]
            st[msp_pkg::ST_UNDERRUN]  = s_q.und;
            st[msp_pkg::ST_DATA_PAR]  = s_q.is_read ? (s_q.rd_ok && !s_q.und && ^s_q.rdata)
                                                    : ^s_q.sr[23:0];   // [R13] [R15]
            st[msp_pkg::ST_MISMATCH]  = s_q.mism;
            st[msp_pkg::ST_BAD_COUNT] = (s_q.cnt != msp_pkg::TXN_BITS);             // [R16]
            st[msp_pkg::ST_BAD_ADDR]  = s_q.bad_addr;
            s_d.status = s_q.rst_seen ? 7'h00 : st;
            if (wr_ok && !ovr)
            begin
                s_d.req   = 1'h1;                    // [R12]
                s_d.we    = 1'h1;
                s_d.maddr = s_q.addr;
                s_d.wdata = s_q.sr[23:0];
                ev[msp_pkg::EV_WRITE_DONE] = 1'h1;
            end
            ev[msp_pkg::EV_TXN_ERROR] = (s_d.status != 7'h00);
        end

        // Sticky events, set wins over clear
        s_d.istat = (s_q.istat & ~clr) | ev;
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            s_q       <= '0;
            s_q.ctrl  <= msp_pkg::CTRL_RST;
            s_q.imask <= msp_pkg::IRQ_MASK_RST;
        end
        else if (ce)
            s_q <= s_d;
    end

    assign spi_miso      = s_q.miso;
    assign spi_miso_oe   = s_q.oe;
    assign dev_reset_req = s_q.rst_pulse;
    assign irq           = |(s_q.istat & s_q.imask);
    assign mem_req       = s_q.req;
    assign mem_we        = s_q.we;
    assign mem_addr      = s_q.maddr;
    assign mem_wdata     = s_q.wdata;
    assign hreadyout     = 1'h1;
    assign hresp         = 1'h0;
    assign hrdata        = s_q.hrdata;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_len_flag;
        ce && cs_rise && s_q.cnt != msp_pkg::TXN_BITS && !s_q.rst_seen |=> s_q.status[msp_pkg::ST_BAD_COUNT];
    endproperty
    a_len_flag: assert property (p_len_flag) else $error("bad length not flagged"); // [R01]

    property p_len_noacc;
        ce && cs_rise && s_q.cnt != msp_pkg::TXN_BITS && !s_q.req |=> !mem_req;
    endproperty
    a_len_noacc: assert property (p_len_noacc) else $error("access on bad length"); // [R02]

    property p_mism_noacc;
        ce && cs_rise && (s_q.mism || s_q.bad_addr) && !s_q.req |=> !mem_req;
    endproperty
    a_mism_noacc: assert property (p_mism_noacc) else $error("access despite field error"); // [R03]

    property p_extra_zero;
        ce && !cs_n && sck_fall && s_q.cnt >= msp_pkg::TXN_BITS |=> !spi_miso;
    endproperty
    a_extra_zero: assert property (p_extra_zero) else $error("surplus clock output not zero"); // [R04]

    property p_wr_abort;
        ce && cs_rise && s_q.cnt > msp_pkg::TXN_BITS && !s_q.is_read && !s_q.req
            |=> !mem_req && s_q.status[msp_pkg::ST_BAD_COUNT];
    endproperty
    a_wr_abort: assert property (p_wr_abort) else $error("long write not aborted"); // [R05]

    property p_stat_par;
        ce && !cs_n && sck_fall && s_q.cnt == msp_pkg::STATUS_START |=> spi_miso == ^s_q.status;
    endproperty
    a_stat_par: assert property (p_stat_par) else $error("status parity wrong"); // [R06]

    property p_safe;
        ce && $rose(mem_req) && s_q.ctrl[msp_pkg::CTRL_SAFE] && $stable(s_q.ctrl) |-> mem_addr <= msp_pkg::SAFE_LIMIT;
    endproperty
    a_safe: assert property (p_safe) else $error("window violated"); // [R07]

    sequence s_rst_seen;
        dev_reset_req ##1 !dev_reset_req;
    endsequence
    property p_rst;
        ce && dev_reset_req |-> s_rst_seen and (##1 s_q.istat[msp_pkg::EV_RESET_CMD]);
    endproperty
    a_rst: assert property (p_rst) else $error("reset command handling wrong"); // [R10]

    property p_miso_edge;
        $changed(spi_miso) |-> $past(sck_fall || cs_fall || cs_rise);
    endproperty
    a_miso_edge: assert property (p_miso_edge) else $error("output moved off falling edge"); // [R17]

    property p_wr_go;
        ce && cs_rise && s_q.cnt == msp_pkg::TXN_BITS && !s_q.is_read && !s_q.mism && !s_q.bad_addr
            && !s_q.rst_seen && !s_q.req |=> mem_req && mem_we && mem_wdata == $past(s_q.sr[23:0]);
    endproperty
    a_wr_go: assert property (p_wr_go) else $error("good write not issued"); // [R12]

endmodule : msp_host_port

/* shared/msp_pkg.sv */
// Constants shared by the metering SPI host port
package msp_pkg;

    // ==========================================================
    // Transaction framing
    localparam int unsigned CNT_W          = 7;
    localparam logic [6:0]  TXN_BITS       = 7'h40;
    localparam logic [6:0]  CNT_MAX        = 7'h7F;
    localparam logic [6:0]  ADDR_DONE_CNT  = 7'h1F;
    localparam logic [6:0]  STATUS_START   = 7'h20;
    localparam logic [6:0]  DATA_START     = 7'h28;
    localparam logic [6:0]  RST_LAST_CNT   = 7'h27;
    localparam logic [39:0] RESET_SEQ      = 40'hA2_0107_F9E6;
    localparam logic [14:0] SAFE_LIMIT     = 15'h00FF;

    // ==========================================================
    // Status byte field positions
    localparam int unsigned ST_PARITY      = 7;
    localparam int unsigned ST_OVERRUN     = 6;
    localparam int unsigned ST_UNDERRUN    = 5;
    localparam int unsigned ST_DATA_PAR    = 4;
    localparam int unsigned ST_MISMATCH    = 3;
    localparam int unsigned ST_BAD_COUNT   = 1;
    localparam int unsigned ST_BAD_ADDR    = 0;

    // ==========================================================
    // Register map, byte addresses
    localparam logic [7:0]  OFS_CTRL       = 8'h00;
    localparam logic [7:0]  OFS_IRQ_STAT   = 8'h04;
    localparam logic [7:0]  OFS_IRQ_MASK   = 8'h08;
    localparam logic [7:0]  OFS_SPI_STATUS = 8'h0C;
    localparam int unsigned CTRL_REDUNDANT = 0;
    localparam int unsigned CTRL_SAFE      = 1;
    localparam int unsigned EV_RESET_CMD   = 0;
    localparam int unsigned EV_TXN_ERROR   = 1;
    localparam int unsigned EV_WRITE_DONE  = 2;
    localparam logic [1:0]  CTRL_RST       = 2'h0;
    localparam logic [2:0]  IRQ_MASK_RST   = 3'h0;

endpackage : msp_pkg

/* rtl/msp_pin_sync.sv */
// Two-stage pin synchroniser with edge detection
`timescale 1ns/100ps

module msp_pin_sync #(
    parameter int unsigned W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic         ce,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] lvl,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
    } msp_sync_t;

    msp_sync_t s_q;
    msp_sync_t s_d;

    always_comb
    begin
        s_d = s_q;
        if (ce)
        begin
            s_d.s1 = din;
            s_d.s2 = s_q.s1;
            s_d.s3 = s_q.s2;
        end
    end

    always_ff @(posedge clk)
    begin
        if (sys_rst)
            s_q <= {RST_VAL, RST_VAL, RST_VAL};
        else
            s_q <= s_d;
    end

    assign lvl  = s_q.s2;
    assign rise = s_q.s2 & ~s_q.s3;
    assign fall = ~s_q.s2 & s_q.s3;

endmodule : msp_pin_sync

/* bench/msp_host_model.sv */
// Host-side SPI master model for the metering host port
`timescale 1ns/100ps

module msp_host_model (
    output logic      spi_sck,
    output logic      chip_select_n,
    output logic      spi_mosi,
    input  wire logic spi_miso
);
    // ====
    // Frame engine, serial clock idles low
    initial
    begin
        spi_sck = 1'b0;
        chip_select_n = 1'b1;
        spi_mosi = 1'b0;
    end

    task automatic xfer(input logic [63:0] tx, input int n, output logic [71:0] rx);
        rx = '0;
        #3;
        chip_select_n = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            spi_mosi = (i < 64) ? tx[63-i] : 1'b0;
            #80;
            spi_sck = 1'b1;
            rx = {rx[70:0], spi_miso};
            #80;
            spi_sck = 1'b0;
        end
        #80;
        chip_select_n = 1'b1;
        spi_mosi = ~spi_mosi;
    endtask : xfer
endmodule : msp_host_model

/* bench/tb_metering_spi_host_port.sv */
// Self-checking bench for the metering SPI host port
`timescale 1ns/100ps

module tb_metering_spi_host_port;
    logic        clk, sys_rst, ce, spi_sck, chip_select_n, spi_mosi, spi_miso, spi_miso_oe;
    logic        dev_reset_req, irq, mem_req, mem_we, mem_ack, hsel, hwrite, hready, hreadyout, hresp;
    logic [14:0] mem_addr, a;
    logic [23:0] mem_wdata, mem_rdata, d;
    logic [31:0] haddr, hwdata, hrdata;
    logic [31:0] xs = 32'h0000_7E12;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [6:0]  prev_st = 7'h00;
    int          bad_count = 0, samples_checked = 0, ram_delay = 2, cnt = 0, rst_pulses = 0;
    logic [23:0] ram [logic [14:0]];
    string       exp_name [$];
    logic [63:0] exp_val [$], got_val [$];
    wire         miso_line = spi_miso_oe ? spi_miso : 1'bz;

    assign hready = hreadyout;
    always #5 clk = ~clk;

    msp_host_port DUT (
        .clk(clk), .sys_rst(sys_rst), .ce(ce), .spi_sck(spi_sck), .chip_select_n(chip_select_n),
        .spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe), .dev_reset_req(dev_reset_req),
        .irq(irq), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata)
    );
    msp_host_model host (.spi_sck(spi_sck), .chip_select_n(chip_select_n), .spi_mosi(spi_mosi),
                         .spi_miso(miso_line));

    // ====
    // Word memory stand-in with adjustable latency
    always @(posedge clk)
    begin
        if (!sys_rst && mem_req && !mem_ack && cnt >= ram_delay)
        begin
            mem_ack <= 1'b1;
            cnt <= 0;
            if (mem_we)
            begin
                ram[mem_addr] = mem_wdata;
                got_val.push_back({25'h000_0000, mem_addr, mem_wdata});
            end
            mem_rdata <= ram.exists(mem_addr) ? ram[mem_addr] : 24'h00_0000;
        end
        else
        begin
            mem_ack <= 1'b0;
            mem_rdata <= ~mem_rdata;
            cnt <= (!sys_rst && mem_req && !mem_ack) ? cnt + 1 : 0;
        end
    end

    // Result watcher pairs each seen value with the oldest note
    always @(posedge clk)
    begin
        if (dev_reset_req === 1'b1)
            rst_pulses++;
        while (got_val.size() > 0 && exp_val.size() > 0)
            check(exp_name.pop_front(), got_val.pop_front(), exp_val.pop_front());
    end

    // ====
    // Helpers
    function automatic logic [31:0] xorshift(input logic [31:0] v);
        logic [31:0] t;
        t = v ^ (v << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xorshift

    function automatic logic [14:0] rev15(input logic [14:0] v);
        for (int i = 0; i < 15; i++)
            rev15[i] = v[14-i];
    endfunction : rev15

    function automatic logic [6:0] pb(input logic [23:0] v);
        return {2'b00, ^v, 4'h0};
    endfunction : pb

    function automatic logic [63:0] rd_frame(input logic [14:0] ad, input logic [14:0] c);
        return {ad, 1'b1, c, 1'b0, 32'h0000_0000};
    endfunction : rd_frame

    function automatic logic [63:0] wr_frame(input logic [14:0] ad, input logic [14:0] c, input logic [23:0] v);
        return {ad, 1'b0, c, 1'b1, 8'h00, v};
    endfunction : wr_frame

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : wrap_up

    task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic note(input string nm, input logic [63:0] v);
        exp_name.push_back(nm);
        exp_val.push_back(v);
    endtask : note

    task automatic wait_rdy();
        int k;
        k = 0;
        @(posedge clk);
        while (hready !== 1'b1 && k < 20)
        begin
            @(posedge clk);
            k++;
        end
        if (k >= 20)
        begin
            bad_count++;
            wrap_up();
        end
    endtask : wait_rdy

    task automatic ahb(input logic wr, input logic [7:0] ad, input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h00_0000, ad};
        hwrite <= wr;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask : ahb

    task automatic reg_wr(input logic [7:0] ad, input logic [31:0] v);
        logic [31:0] r;
        ahb(1'b1, ad, v, r);
    endtask : reg_wr

    task automatic reg_chk(input string nm, input logic [7:0] ad, input logic [31:0] v);
        logic [31:0] r;
        note(nm, 64'(v));
        note("hresp_ready", 64'h1);
        ahb(1'b0, ad, 32'h0000_0000, r);
        got_val.push_back(64'(r));
        got_val.push_back(64'({hresp, hreadyout}));
    endtask : reg_chk

    task automatic irq_chk(input logic v);
        note("irq", 64'(v));
        @(negedge clk);
        got_val.push_back(64'(irq));
    endtask : irq_chk

    task automatic frame(input logic [63:0] tx, input int n, input logic [6:0] nxt, input logic [23:0] v);
        logic [71:0] rx;
        note("status", 64'({^prev_st, prev_st}));
        if (n >= 64)
            note("data", 64'(v));
        if (n > 64)
            note("surplus", 64'h0000_0000_0000_0000);
        note("miso_oe", 64'h0000_0000_0000_0000);
        host.xfer(tx, n, rx);
        got_val.push_back(64'(rx[n-33 -: 8]));
        if (n >= 64)
            got_val.push_back(64'(rx[n-41 -: 24]));
        if (n > 64)
            got_val.push_back(64'(rx[7:0]));
        prev_st = nxt;
        repeat (4) @(posedge clk);
        got_val.push_back(64'(spi_miso_oe));
        repeat (36) @(posedge clk);
    endtask : frame

    task automatic wframe(input logic [14:0] ad, input logic [14:0] c, input logic [23:0] v, input logic ok,
                          input logic [6:0] nxt);
        frame(wr_frame(ad, c, v), 64, nxt, 24'h00_0000);
        if (ok)
            note("write", {25'h000_0000, ad, v});
    endtask : wframe

    // ====
    // Main sequence
    initial
    begin
        clk = 1'b0;
        sys_rst <= 1'b1;
        ce <= 1'b1;
        hsel <= 1'b0;
        haddr <= 32'h0000_0000;
        htrans <= 2'b00;
        hwrite <= 1'b0;
        hsize <= 3'b010;
        hwdata <= 32'h0000_0000;
        mem_ack <= 1'b0;
        mem_rdata <= 24'h00_0000;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 5; i++)
            reg_chk("reg_reset", 8'(i * 4), 32'h0000_0000);
        for (int i = 0; i < 3; i++)
        begin
            xs = xorshift(xs);
            a = xs[14:0];
            d = xs[31:8];
            wframe(a, rev15(a), d, 1'b1, pb(d));
            frame(rd_frame(a, ~a), 64, pb(d), d);
        end
        wframe(15'h0033, 15'h0000, 24'h00_0007, 1'b1, pb(24'h00_0007));
        frame(wr_frame(15'h0044, rev15(15'h0044), 24'h00_0000) & ~(64'h1 << 32), 64, 7'h08, 24'h00_0000);
        frame(rd_frame(15'h0033, ~15'h0033) | (64'h1 << 32), 64, 7'h08, 24'h00_0000);
        frame(wr_frame(15'h0044, rev15(15'h0044), 24'h00_0000), 63, 7'h02, 24'h00_0000);
        frame(wr_frame(15'h0044, rev15(15'h0044), 24'h00_0000), 72, 7'h02, 24'h00_0000);
        frame(rd_frame(15'h0033, ~15'h0033), 72, 7'h02 | pb(24'h00_0007), 24'h00_0007);
        reg_wr(msp_pkg::OFS_CTRL, 32'h0000_0001);
        reg_chk("ctrl", msp_pkg::OFS_CTRL, 32'h0000_0001);
        wframe(15'h0012, ~15'h0012, 24'h00_0000, 1'b0, 7'h08);
        wframe(15'h0012, rev15(15'h0012), 24'h12_3456, 1'b1, pb(24'h12_3456));
        frame(rd_frame(15'h0012, rev15(15'h0012)), 64, 7'h08, 24'h00_0000);
        frame(rd_frame(15'h0012, ~15'h0012), 64, pb(24'h12_3456), 24'h12_3456);
        reg_wr(msp_pkg::OFS_CTRL, 32'h0000_0002);
        wframe(15'h0100, rev15(15'h0100), 24'h00_0000, 1'b0, 7'h01);
        wframe(15'h00FF, rev15(15'h00FF), 24'h00_0001, 1'b1, pb(24'h00_0001));
        frame(rd_frame(15'h0100, ~15'h0100), 64, 7'h01, 24'h00_0000);
        reg_wr(msp_pkg::OFS_CTRL, 32'h0000_0000);
        for (int b = 0; b < 2; b++)
            frame({40'hA2_0107_F9E6 | 40'(b), 24'h00_0000}, 40, 7'h00, 24'h00_0000);
        note("reset_pulses", 64'(2));
        got_val.push_back(64'(rst_pulses));
        // Slow memory: second write collides, then a late read
        ram_delay = 1200;
        wframe(15'h0005, rev15(15'h0005), 24'h00_0001, 1'b0, 7'h10);
        wframe(15'h0006, rev15(15'h0006), 24'h00_0003, 1'b0, 7'h40);
        note("write", {25'h000_0000, 15'h0005, 24'h00_0001});
        frame(rd_frame(15'h0005, ~15'h0005), 64, 7'h20, 24'h00_0000);
        for (int k = 0; k < 3000 && mem_req !== 1'b0; k++)
            @(posedge clk);
        if (mem_req !== 1'b0)
        begin
            bad_count++;
            wrap_up();
        end
        ram_delay = 2;
        frame(rd_frame(15'h0012, ~15'h0012), 64, pb(24'h12_3456), 24'h12_3456);
        reg_chk("spi_status", msp_pkg::OFS_SPI_STATUS, {24'h00_0000, ^prev_st, prev_st});
        reg_chk("irq_stat", msp_pkg::OFS_IRQ_STAT, 32'h0000_0007);
        irq_chk(1'b0);
        reg_wr(msp_pkg::OFS_IRQ_MASK, 32'h0000_0002);
        irq_chk(1'b1);
        reg_wr(msp_pkg::OFS_IRQ_STAT, 32'h0000_0002);
        reg_chk("irq_stat", msp_pkg::OFS_IRQ_STAT, 32'h0000_0005);
        irq_chk(1'b0);
        reg_chk("irq_mask", msp_pkg::OFS_IRQ_MASK, 32'h0000_0002);
        repeat (5) @(posedge clk);
        if (exp_val.size() != 0 || got_val.size() != 0)
            bad_count++;
        wrap_up();
    end
endmodule : tb_metering_spi_host_port
